// ==== design/sbsr_status.v ====
// Purpose: Status byte, event registers and service request of an instrument.
// Assumes: Command parser decodes queries and writes onto one-cycle strobes.
// Notes:   Event inputs are pulses from logic on ref_clk.
// Function
// RULE1: Master summary is OR of status byte bits enabled by service enable.
// RULE2: Rising enabled summary raises request bit and asserts service request line.
// RULE3: Serial poll delivers the full eight-bit status byte.
// RULE4: Request bit follows the issued request, cleared as serial poll reads.
// RULE5: Status byte query returns master summary without clearing it.
// RULE6: Bit 4 is high exactly while output queue holds a message.
// RULE7: Service enable bit one lets its status bit reach summary and request.
// RULE8: Bit 5 set when any enabled standard event bit is set.
// RULE9: Standard event enable bit gates its status bit into the summary.
// RULE10: Standard event register cleared by clear-status, its query, power-on.
// RULE11: Standard event bit 7 set at power-on.
// RULE12: Standard event bit 5 set on command syntax or semantic fault.
// RULE13: Standard event bit 4 set on execution fault.
// RULE14: Standard event bit 3 set on device-dependent fault.
// RULE15: Standard event bit 2 set and queue cleared on query fault.
// RULE16: Standard event bit 0 set when operation-complete finishes.
// RULE17: Device event registers summarise into status bits 0 and 1.
// RULE18: Device event registers cleared by clear-status, own query, power-on.
// RULE19: Measurement event register holds seven measurement events, bit 7 unused.
// RULE20: Monitor fault register holds four faults, bits 7 to 4 unused.
// RULE21: Service requests only on parallel bus; serial link query still works.
// RULE22: Clear-status clears all status byte bits except message available.
// RULE23: Parallel device clear clears message available with buffers.
// RULE24: Unused bits read zero and never reach any summary.
`include "sbsr_regs.vh"
module sbsr_status (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       arst_n,
  // Command port
  input  wire       cmd_wr,
  input  wire       cmd_rd,
  input  wire [2:0] cmd_sel,
  input  wire [7:0] cmd_wdata,
  input  wire       cmd_serial_link,
  input  wire       clear_status,
  input  wire       device_clear,
  output reg  [7:0] cmd_rdata,
  output reg        cmd_rvalid,
  // Parallel bus serial poll
  input  wire       poll_rd,
  output reg  [7:0] poll_data,
  output reg        poll_valid,
  output reg        srq_out,
  // Output queue
  input  wire       queue_not_empty,
  output reg        queue_clear,
  // Standard events
  input  wire       cmd_fault,
  input  wire       exec_fault,
  input  wire       dev_fault,
  input  wire       query_empty_read,
  input  wire       query_overflow,
  input  wire       query_new_cmd,
  input  wire       op_complete,
  // Measurement events
  input  wire       measurement_done,
  input  wire       conversion_done,
  input  wire       compare_low_result,
  input  wire       compare_pass_result,
  input  wire       compare_high_result,
  input  wire       measurement_fault,
  input  wire       out_of_range_fault,
  // Monitor faults
  input  wire       contact_check_low_fault,
  input  wire       contact_check_high_fault,
  input  wire       current_monitor_fault,
  input  wire       voltage_monitor_fault
);

  reg  [7:0] sre_reg;
  reg  [7:0] see_reg;
  reg  [7:0] mee_reg;
  reg  [7:0] mfe_reg;
  reg  [7:0] ses_reg;
  reg  [7:0] mes_reg;
  reg  [7:0] mfs_reg;
  reg        mav_reg;
  reg        rqs_reg;
  reg        mss_prev_reg;
  reg  [7:0] ses_next;
  reg  [7:0] mes_next;
  reg  [7:0] mfs_next;
  reg  [7:0] sby_sum;
  reg  [7:0] sby_val;
  reg        mss;
  reg  [7:0] rd_mux;
  wire       query_fault;
  wire       rd_ses;
  wire       rd_mes;
  wire       rd_mfs;

  // Any enabled set bit within a register.
  function summary;
    input [7:0] status;
    input [7:0] enable;
    input [7:0] implemented;
    begin
      summary = |(status & enable & implemented);
    end
  endfunction

  assign query_fault = query_empty_read | query_overflow | query_new_cmd;
  assign rd_ses = cmd_rd & (cmd_sel == `SBSR_SEL_SES);
  assign rd_mes = cmd_rd & (cmd_sel == `SBSR_SEL_MES);
  assign rd_mfs = cmd_rd & (cmd_sel == `SBSR_SEL_MFS);

  // Summary bits and the master summary, shared by poll and query paths.
  always @* begin
    sby_sum = `SBSR_ZERO;
    // RULE17 device summaries
    sby_sum[`SBSR_SBY_MES] = summary(mes_reg, mee_reg, `SBSR_MES_MASK);
    sby_sum[`SBSR_SBY_MFS] = summary(mfs_reg, mfe_reg, `SBSR_MFS_MASK);
    // RULE6 message available
    sby_sum[`SBSR_SBY_MAV] = mav_reg;
    // RULE8 RULE9 standard summary
    sby_sum[`SBSR_SBY_SES] = summary(ses_reg, see_reg, `SBSR_SES_MASK);
    // RULE1 RULE7 RULE24 master summary
    mss = summary(sby_sum, sre_reg, `SBSR_SBY_MASK);
    sby_val = sby_sum;
    sby_val[`SBSR_SBY_RQS] = mss;
  end

  // Event set paths; a set in the same cycle as a clear wins.
  always @* begin
    ses_next = ses_reg;
    if (clear_status | rd_ses) begin
      // RULE10 standard clear
      ses_next = `SBSR_ZERO;
    end
    // RULE12 RULE13 RULE14 fault flags
    if (cmd_fault) ses_next[`SBSR_SE_CME] = 1'b1;
    if (exec_fault) ses_next[`SBSR_SE_EXE] = 1'b1;
    if (dev_fault) ses_next[`SBSR_SE_DDE] = 1'b1;
    // RULE15 query fault flag
    if (query_fault) ses_next[`SBSR_SE_QYE] = 1'b1;
    // RULE16 operation complete
    if (op_complete) ses_next[`SBSR_SE_OPC] = 1'b1;
    mes_next = mes_reg;
    mfs_next = mfs_reg;
    // RULE18 device clears
    if (clear_status | rd_mes) mes_next = `SBSR_ZERO;
    if (clear_status | rd_mfs) mfs_next = `SBSR_ZERO;
    // RULE19 measurement events
    mes_next = (mes_next | {1'b0, out_of_range_fault, measurement_fault, compare_high_result,
               compare_pass_result, compare_low_result, conversion_done, measurement_done})
               & `SBSR_MES_MASK;
    // RULE20 monitor faults
    mfs_next = (mfs_next | {4'h0, voltage_monitor_fault, current_monitor_fault,
               contact_check_high_fault, contact_check_low_fault}) & `SBSR_MFS_MASK;
  end

  // Query read multiplexer; unused bits are masked to zero.
  always @* begin
    case (cmd_sel)
      // RULE5 query keeps summary
      `SBSR_SEL_SBY: rd_mux = sby_val;
      `SBSR_SEL_SRE: rd_mux = sre_reg;
      `SBSR_SEL_SES: rd_mux = ses_reg;
      `SBSR_SEL_SEE: rd_mux = see_reg;
      `SBSR_SEL_MES: rd_mux = mes_reg;
      `SBSR_SEL_MEE: rd_mux = mee_reg;
      `SBSR_SEL_MFS: rd_mux = mfs_reg;
      `SBSR_SEL_MFE: rd_mux = mfe_reg;
      default:       rd_mux = `SBSR_ZERO;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sre_reg      <= `SBSR_ZERO;
      see_reg      <= `SBSR_ZERO;
      mee_reg      <= `SBSR_ZERO;
      mfe_reg      <= `SBSR_ZERO;
      // RULE11 power-on flag
      ses_reg      <= `SBSR_SES_RST;
      mes_reg      <= `SBSR_ZERO;
      mfs_reg      <= `SBSR_ZERO;
      mav_reg      <= 1'b0;
      rqs_reg      <= 1'b0;
      mss_prev_reg <= 1'b0;
      cmd_rdata    <= `SBSR_ZERO;
      cmd_rvalid   <= 1'b0;
      poll_data    <= `SBSR_ZERO;
      poll_valid   <= 1'b0;
      srq_out      <= 1'b0;
      queue_clear  <= 1'b0;
    end else begin
      // RULE21 enables writable on both links
      if (cmd_wr) begin
        case (cmd_sel)
          `SBSR_SEL_SRE: sre_reg <= cmd_wdata & `SBSR_SBY_MASK;
          `SBSR_SEL_SEE: see_reg <= cmd_wdata & `SBSR_SES_MASK;
          `SBSR_SEL_MEE: mee_reg <= cmd_wdata & `SBSR_MES_MASK;
          `SBSR_SEL_MFE: mfe_reg <= cmd_wdata & `SBSR_MFS_MASK;
          default: ;
        endcase
      end
      ses_reg <= ses_next;
      mes_reg <= mes_next;
      mfs_reg <= mfs_next;
      // RULE6 RULE23 queue state, emptied by device clear or query fault
      mav_reg <= queue_not_empty & ~device_clear & ~query_fault;
      // RULE15 RULE23 queue flush
      queue_clear <= query_fault | device_clear;
      mss_prev_reg <= mss & ~clear_status;
      // RULE2 RULE4 RULE21 request on rising summary, poll clears, new rise wins
      if (mss & ~mss_prev_reg & ~cmd_serial_link) begin
        rqs_reg <= 1'b1;
      end else if (poll_rd | clear_status | ~mss) begin
        // RULE22 clear-status drops request
        rqs_reg <= 1'b0;
      end
      srq_out <= rqs_reg & ~poll_rd & ~clear_status;
      // RULE3 serial poll byte with request bit
      poll_valid <= poll_rd;
      if (poll_rd) begin
        poll_data <= {sby_val[7], rqs_reg, sby_val[5:0]};
      end
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        cmd_rdata <= rd_mux;
      end
    end
  end

endmodule // sbsr_status

// ==== common/sbsr_regs.vh ====
// Purpose: Constants for the status byte and service request block.
// Assumes: Register codes select registers on the command port.
// Notes:   Codes are plain selectors, not bus addresses.
`ifndef SBSR_REGS_VH
`define SBSR_REGS_VH
// Register select codes.
`define SBSR_SEL_SBY   3'h0
`define SBSR_SEL_SRE   3'h1
`define SBSR_SEL_SES   3'h2
`define SBSR_SEL_SEE   3'h3
`define SBSR_SEL_MES   3'h4
`define SBSR_SEL_MEE   3'h5
`define SBSR_SEL_MFS   3'h6
`define SBSR_SEL_MFE   3'h7
// Status byte fields.
`define SBSR_SBY_MES   0
`define SBSR_SBY_MFS   1
`define SBSR_SBY_MAV   4
`define SBSR_SBY_SES   5
`define SBSR_SBY_RQS   6
// Standard event fields.
`define SBSR_SE_OPC    0
`define SBSR_SE_QYE    2
`define SBSR_SE_DDE    3
`define SBSR_SE_EXE    4
`define SBSR_SE_CME    5
`define SBSR_SE_PON    7
// Implemented-bit masks and reset values.
`define SBSR_SBY_MASK  8'h73
`define SBSR_SES_MASK  8'hbd
`define SBSR_MES_MASK  8'h7f
`define SBSR_MFS_MASK  8'h0f
`define SBSR_SES_RST   8'h80
`define SBSR_ZERO      8'h00
`endif

// ==== test/sbsr_status_properties.sv ====
// Purpose: Port assertions for sbsr_status.
// Assumes: One clock, reset low.
// Notes:   Bound into every instance.
module sbsr_status_properties (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       cmd_wr,
  input wire logic       cmd_rd,
  input wire logic [2:0] cmd_sel,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic       cmd_rvalid,
  input wire logic       poll_rd,
  input wire logic [7:0] poll_data,
  input wire logic       poll_valid,
  input wire logic       srq_out,
  input wire logic       queue_not_empty
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  rd_answer_a: assert property (cmd_rd |=> cmd_rvalid) else $error("no query answer");
  poll_answer_a: assert property (poll_rd |=> poll_valid) else $error("no poll answer");
  poll_clears_a: assert property (poll_rd && srq_out |=> !srq_out && poll_data[6]) else $error("poll clear");
  byte_unused_a: assert property (poll_valid |-> (poll_data & 8'h8c) == 8'h00) else $error("byte unused");
  mav_low_a: assert property (cmd_rd && cmd_sel == 3'h0 && !queue_not_empty && !$past(queue_not_empty)
    |=> !cmd_rdata[4]) else $error("mav set");
  see_back_a: assert property (cmd_wr && cmd_sel == 3'h3 ##1 cmd_rd && cmd_sel == 3'h3 && !cmd_wr
    |=> (cmd_rdata & 8'hbd) == ($past(cmd_wdata, 2) & 8'hbd)) else $error("enable readback");
  mes_unused_a: assert property (cmd_rd && cmd_sel == 3'h4 |=> !cmd_rdata[7]) else $error("mes bit7");
  mfs_unused_a: assert property (cmd_rd && cmd_sel == 3'h6 |=> cmd_rdata[7:4] == 4'h0) else $error("mfs high");
endmodule // sbsr_status_properties
bind sbsr_status sbsr_status_properties i_props (.ref_clk, .arst_n, .cmd_wr, .cmd_rd, .cmd_sel, .cmd_wdata,
  .cmd_rdata, .cmd_rvalid, .poll_rd, .poll_data, .poll_valid, .srq_out, .queue_not_empty);

// ==== test/sbsr_ctrl_model.sv ====
// Purpose: Bus controller that serial-polls on a request.
// Assumes: Requests move on the rising edge, polls on the falling edge.
// Notes:   Poll delay makes it prompt or slow.
module sbsr_ctrl_model (
  input  wire logic [0:0] ref_clk,
  input  wire logic [0:0] srq_out,
  input  wire logic [7:0] poll_data,
  input  wire logic [3:0] poll_delay,
  output logic      [0:0] poll_rd,
  output logic      [7:0] poll_byte,
  output logic      [7:0] poll_count
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    poll_rd = 1'b0;
    poll_byte = 8'h00;
    poll_count = 8'h00;
    forever begin
      @(negedge ref_clk);
      if (srq_out === 1'b1) begin
        repeat (poll_delay) @(negedge ref_clk);
        poll_rd = 1'b1;
        @(negedge ref_clk);
        poll_rd = 1'b0;
        poll_byte = poll_data;
        poll_count = poll_count + 8'h01;
      end
    end
  end
endmodule // sbsr_ctrl_model

// ==== test/tb.sv ====
// Purpose: Random and corner checks of sbsr_status.
// Assumes: Inputs move on the falling edge.
// Notes:   Query faults stay out of the random mix.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SE_POS [7] = '{5, 4, 3, 2, 2, 2, 0};
  logic       ref_clk = 1'b0, arst_n = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0, serial = 1'b0, clr = 1'b0, qne = 1'b0;
  logic       dclr = 1'b0;
  wire        qclr;
  logic [2:0] cmd_sel = 3'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic [6:0] se = 7'h00, me = 7'h00;
  logic [3:0] mf = 4'h0, dly = 4'h0;
  wire  [7:0] rdata, pdata, pbyte, npoll;
  wire        rvalid, prd, srq;
  int         error_cnt = 0;
  int         cmp_count = 0;
  always #2 ref_clk = ~ref_clk;
  sbsr_status i_dut (.ref_clk, .arst_n, .cmd_wr, .cmd_rd, .cmd_sel, .cmd_wdata, .cmd_serial_link(serial),
    .clear_status(clr), .device_clear(dclr), .cmd_rdata(rdata), .cmd_rvalid(rvalid), .poll_rd(prd),
    .poll_data(pdata), .poll_valid(), .srq_out(srq), .queue_not_empty(qne), .queue_clear(qclr),
    .cmd_fault(se[0]), .exec_fault(se[1]), .dev_fault(se[2]), .query_empty_read(se[3]),
    .query_overflow(se[4]), .query_new_cmd(se[5]), .op_complete(se[6]), .measurement_done(me[0]),
    .conversion_done(me[1]), .compare_low_result(me[2]), .compare_pass_result(me[3]),
    .compare_high_result(me[4]), .measurement_fault(me[5]), .out_of_range_fault(me[6]),
    .contact_check_low_fault(mf[0]), .contact_check_high_fault(mf[1]),
    .current_monitor_fault(mf[2]), .voltage_monitor_fault(mf[3]));
  sbsr_ctrl_model i_ctrl (.ref_clk, .srq_out(srq), .poll_data(pdata), .poll_delay(dly), .poll_rd(prd),
    .poll_byte(pbyte), .poll_count(npoll));
  function automatic logic [7:0] sby_exp(input logic [7:0] sre, see, mee, mfe,
    input logic [6:0] rs, rm, input logic [3:0] rf, input logic q);
    logic [7:0] ses, b;
    ses = {2'b00, rs[0], rs[1], rs[2], |rs[5:3], 1'b0, rs[6]};
    b = {2'b00, |(ses & see), q, 2'b00, |(rf & mfe[3:0]), |(rm & mee[6:0])};
    b[6] = |(b & sre);
    return b;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    cmd_wr = 1'b1;
    cmd_sel = s;
    cmd_wdata = d;
    @(negedge ref_clk);
    cmd_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    cmd_rd = 1'b1;
    cmd_sel = s;
    @(negedge ref_clk);
    cmd_rd = 1'b0;
    chk(rvalid === 1'b1 ? rdata : ~e, e);
  endtask
  task automatic ev(input logic [6:0] s, m, input logic [3:0] f);
    se = s;
    me = m;
    mf = f;
    @(negedge ref_clk);
    se = 7'h00;
    me = 7'h00;
    mf = 4'h0;
  endtask
  task automatic end_of_test;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    int i, n;
    logic [7:0] sre, see, mee, mfe, exp, np;
    logic [6:0] rs, rm;
    logic [3:0] rf;
    n = $urandom(32'hb1ea6205);
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    rd(3'h2, 8'h80);
    rd(3'h2, 8'h00);
    wr(3'h3, 8'h35);
    rd(3'h3, 8'h35);
    for (i = 0; i < 7; i++) begin
      ev(7'h01 << i, 7'h01 << i, 4'h1 << i);
      rd(3'h2, 8'h01 << SE_POS[i]);
      rd(3'h4, 8'h01 << i);
      rd(3'h6, 8'h01 << i & 8'h0f);
    end
    qne = 1'b1;
    repeat (2) @(negedge ref_clk);
    dclr = 1'b1;
    @(negedge ref_clk);
    dclr = 1'b0;
    chk({7'h00, qclr}, 8'h01);
    rd(3'h0, 8'h00);
    rd(3'h0, 8'h10);
    qne = 1'b0;
    for (i = 0; i < 24; i++) begin
      {sre, see, mee, mfe} = {$urandom & 32'h33ffffff};
      {rs, rm, rf, dly, serial} = 23'($urandom) & 23'h47ffff;
      qne = 1'b0;
      clr = 1'b1;
      @(negedge ref_clk);
      clr = 1'b0;
      wr(3'h1, sre);
      wr(3'h3, see);
      wr(3'h5, mee);
      wr(3'h7, mfe);
      np = npoll;
      qne = 1'($urandom);
      ev(rs, rm, rf);
      exp = sby_exp(sre, see, mee, mfe, rs, rm, rf, qne);
      rd(3'h0, exp);
      rd(3'h0, exp);
      for (n = 0; n < 30 && npoll === np; n++) @(negedge ref_clk);
      chk({7'h00, npoll !== np}, {7'h00, exp[6] & ~serial});
      if (npoll !== np) chk(pbyte, exp);
    end
    end_of_test();
  end
endmodule // tb
